// file: verilog/omc_regs.svh
// Constants of the optical module control and status block: two-wire
// addresses, the control/status byte offset, its field positions and resets.
// Assumes it is included by bare name from the package and the design files.
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

// ----------------------------------------------------------------------------
// Two-wire device addresses (seven-bit form of the 8-bit A0h and A2h codes).
// ----------------------------------------------------------------------------
`define OMC_ID_DEV_ADDR      7'h50
`define OMC_DIAG_DEV_ADDR    7'h51

// ----------------------------------------------------------------------------
// Control and status byte inside the diagnostic memory.
// ----------------------------------------------------------------------------
`define OMC_CTRL_STATUS_OFS  8'h6e
`define OMC_BIT_HW_SHUTOFF   7
`define OMC_BIT_SW_SHUTOFF   6
`define OMC_BIT_TX_FAULT     2
`define OMC_BIT_SIGNAL_LOST  1
`define OMC_SW_SHUTOFF_RST   1'h0
`define OMC_FAULT_RST        1'h0

// ----------------------------------------------------------------------------
// Serial bus framing.
// ----------------------------------------------------------------------------
`define OMC_BITS_PER_BYTE    4'h8
`define OMC_LAST_DATA_BIT    4'h7

`endif

// file: verilog/omc_pkg.sv
// Types shared by the optical module control and status design files.
// Assumes omc_regs.svh is reachable on the include path.
`include "omc_regs.svh"

package omc_pkg;

	// ------------------------------------------------------------------------
	// Two-wire slave states, one-hot.
	// ------------------------------------------------------------------------
	typedef enum logic [8:0]
	{
		OMC_IDLE      = 9'h001,
		OMC_DEV_ADDR  = 9'h002,
		OMC_ACK_DEV   = 9'h004,
		OMC_WORD_ADDR = 9'h008,
		OMC_ACK_WORD  = 9'h010,
		OMC_WR_DATA   = 9'h020,
		OMC_ACK_WR    = 9'h040,
		OMC_RD_DATA   = 9'h080,
		OMC_RD_ACK    = 9'h100
	} omc_state_t;

	// Which memory a transfer addresses.
	typedef enum logic
	{
		OMC_SEL_ID   = 1'b0,
		OMC_SEL_DIAG = 1'b1
	} omc_sel_t;

endpackage : omc_pkg

// file: verilog/omc_laser_guard.sv
// Transmitter guard: combines the shut-off sources, keeps the latched laser
// fault and produces the laser enable. Assumes all inputs are synchronous.
`include "omc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module omc_laser_guard
	import omc_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic hwShutoff,
	input  wire logic softShutoff,
	input  wire logic catastrophicFault,
	input  wire logic unsafeLevel,
	output logic      laserEnable,
	output logic      faultLatched
);

	// ------------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------------
	logic hwPrev;           // Shut-off input seen one cycle earlier.
	logic next_hwPrev;      // Next value of hwPrev.
	logic next_fault;       // Next value of the fault latch.
	logic next_laserEnable; // Next value of the laser enable.
	logic faultSet;         // A fault source is active this cycle.
	logic faultClear;       // The shut-off input has just been asserted.

	// Next values. A set in the clearing cycle wins, so no fault is lost.
	always_comb
	begin
		faultSet = catastrophicFault | unsafeLevel;
		faultClear = hwShutoff & ~hwPrev;
		next_hwPrev = hwShutoff;
		next_fault = faultSet | (faultLatched & ~faultClear);
		// Either shut-off source or any fault keeps the laser dark.
		next_laserEnable = ~(hwShutoff | softShutoff | next_fault);
	end

	// Registers. Reset stands for a power cycle and clears the latch.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			hwPrev <= 1'b1;
			faultLatched <= `OMC_FAULT_RST;
			laserEnable <= 1'b0;
		end
		else
		begin
			hwPrev <= next_hwPrev;
			faultLatched <= next_fault;
			laserEnable <= next_laserEnable;
		end
	end

endmodule : omc_laser_guard

`default_nettype wire

// file: verilog/omc_ctrl_status.sv
// Control and status logic of a pluggable optical transceiver: shut-off
// input, latched laser fault pin, signal-lost pin and a two-wire slave that
// serves the identification memory and the diagnostic control/status byte.
// Assumes pins are synchronous to core_clk and SCL is far slower than it.
`include "omc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module omc_ctrl_status
	import omc_pkg::*;
#(
	parameter bit            DIAG_MONITOR_OPTION = 1'b1, // Diagnostic variant.
	parameter logic [2047:0] ID_CONTENTS         = '0    // Arbitrary ID bytes.
)
(
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Transmit shut-off pin: level and whether the host drives it at all.
	input  wire logic txShutoffLevel,
	input  wire logic txShutoffDriven,
	// Laser fault sources inside the module.
	input  wire logic catastrophicFault,
	input  wire logic unsafeLevel,
	// Receiver transition detector verdict, high when input is unusable.
	input  wire logic signalUnusable,
	// Laser driver enable.
	output logic      laserEnable,
	// Open-collector fault pin; released (high via pull-up) on fault.
	output logic      txFaultOut,
	output logic      txFaultOe,
	// Signal-lost pin.
	output logic      receive_signal_lost,
	// Two-wire bus: clock input and open-drain data.
	input  wire logic scl,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe
);

	// ------------------------------------------------------------------------
	// Pin conditioning and transmitter guard.
	// ------------------------------------------------------------------------
	logic hwShutoff;    // Effective shut-off level after the pull-up.
	logic softShutoff;  // Software shut-off bit of the control byte.
	logic faultLatched; // Latched laser fault from the guard.

	// The internal pull-up makes an undriven pin read as shut off. A host
	// that ties the pin low drives it, so the laser then runs normally.
	assign hwShutoff = txShutoffDriven ? txShutoffLevel : 1'b1;

	// Fault latch and laser enable live in their own small module.
	omc_laser_guard u_guard
	(
		.core_clk          (core_clk),
		.reset_n           (reset_n),
		.hwShutoff         (hwShutoff),
		.softShutoff       (softShutoff),
		.catastrophicFault (catastrophicFault),
		.unsafeLevel       (unsafeLevel),
		.laserEnable       (laserEnable),
		.faultLatched      (faultLatched)
	);

	// The fault pin only ever pulls low; it is released while faulted.
	assign txFaultOut = 1'b0;
	assign txFaultOe = ~faultLatched;

	// ------------------------------------------------------------------------
	// Signal-lost pin.
	// ------------------------------------------------------------------------
	logic next_signalLost; // Next value of the signal-lost pin.

	// The pin follows the detector with one register of delay.
	always_comb
	begin
		next_signalLost = signalUnusable;
	end

	// Register the pin; during reset it shows loss, the safe answer.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			receive_signal_lost <= 1'b1;
		end
		else
		begin
			receive_signal_lost <= next_signalLost;
		end
	end

	// ------------------------------------------------------------------------
	// Read decode.
	// ------------------------------------------------------------------------

	// Byte seen by a read of either memory. Status bits are taken live at
	// the moment the byte is loaded, so each read returns current state.
	function automatic logic [7:0] readByte
	(
		input omc_sel_t   sel,
		input logic [7:0] addr
	);
		logic [7:0] value;
		value = 8'h00;
		if (sel == OMC_SEL_ID)
		begin
			value = ID_CONTENTS[{addr, 3'h0} +: 8];
		end
		else if (addr == `OMC_CTRL_STATUS_OFS)
		begin
			value[`OMC_BIT_HW_SHUTOFF] = hwShutoff;
			value[`OMC_BIT_SW_SHUTOFF] = softShutoff;
			value[`OMC_BIT_TX_FAULT] = faultLatched;
			value[`OMC_BIT_SIGNAL_LOST] = receive_signal_lost;
		end
		return value;
	endfunction : readByte

	// ------------------------------------------------------------------------
	// Two-wire slave.
	// ------------------------------------------------------------------------
	omc_state_t state;         // Slave state.
	omc_state_t next_state;    // Next slave state.
	logic [3:0] bitCnt;        // Bits moved in the current byte.
	logic [3:0] next_bitCnt;   // Next bit count.
	logic [7:0] shiftReg;      // Byte being shifted in or out.
	logic [7:0] next_shiftReg; // Next shift register.
	logic [7:0] wordAddr;      // Memory pointer, advances per byte.
	logic [7:0] next_wordAddr; // Next memory pointer.
	omc_sel_t   devSel;        // Memory chosen by the device address.
	omc_sel_t   next_devSel;   // Next memory choice.
	logic       isRead;        // Current transfer reads.
	logic       next_isRead;   // Next read flag.
	logic       pullLow;       // Slave pulls SDA low.
	logic       next_pullLow;  // Next SDA pull.
	logic       next_soft;     // Next software shut-off bit.
	logic       sclPrev;       // SCL one cycle earlier.
	logic       sdaPrev;       // SDA one cycle earlier.
	logic       sclRise;       // SCL rising edge this cycle.
	logic       sclFall;       // SCL falling edge this cycle.
	logic       startSeen;     // Start or repeated start condition.
	logic       stopSeen;      // Stop condition.
	logic [7:0] loadByte;      // Byte fetched for a read.

	// Bus conditions from the previous and present pin samples.
	assign sclRise = scl & ~sclPrev;
	assign sclFall = ~scl & sclPrev;
	assign startSeen = scl & sclPrev & sdaPrev & ~sdaIn;
	assign stopSeen = scl & sclPrev & ~sdaPrev & sdaIn;

	// Read byte fetch. A process rather than a continuous assignment, so
	// that the status signals read inside the function also wake it.
	always_comb
	begin
		loadByte = readByte(devSel, wordAddr);
	end

	// Open drain: the driven level is always low.
	assign sdaOut = 1'b0;
	assign sdaOe = pullLow;

	// Next-state logic. Data changes only after SCL falls; bits are taken
	// on SCL rising. Start and stop override whatever byte is in progress.
	always_comb
	begin
		next_state = state;
		next_bitCnt = bitCnt;
		next_shiftReg = shiftReg;
		next_wordAddr = wordAddr;
		next_devSel = devSel;
		next_isRead = isRead;
		next_pullLow = pullLow;
		next_soft = softShutoff;
		if (startSeen)
		begin
			next_state = OMC_DEV_ADDR;
			next_bitCnt = 4'h0;
			next_pullLow = 1'b0;
		end
		else if (stopSeen)
		begin
			next_state = OMC_IDLE;
			next_pullLow = 1'b0;
		end
		else
		begin
			case (state)
				OMC_IDLE:
				begin
					next_pullLow = 1'b0;
				end
				OMC_DEV_ADDR, OMC_WORD_ADDR, OMC_WR_DATA:
				begin
					if (sclRise)
					begin
						next_shiftReg = {shiftReg[6:0], sdaIn};
						next_bitCnt = bitCnt + 4'h1;
					end
					else if (sclFall && bitCnt == `OMC_BITS_PER_BYTE)
					begin
						next_pullLow = 1'b1;
						if (state == OMC_DEV_ADDR)
						begin
							next_isRead = shiftReg[0];
							if (shiftReg[7:1] == `OMC_ID_DEV_ADDR)
							begin
								next_devSel = OMC_SEL_ID;
								next_state = OMC_ACK_DEV;
							end
							else if (DIAG_MONITOR_OPTION &&
								shiftReg[7:1] == `OMC_DIAG_DEV_ADDR)
							begin
								next_devSel = OMC_SEL_DIAG;
								next_state = OMC_ACK_DEV;
							end
							else
							begin
								// Another device's address: stay silent.
								next_pullLow = 1'b0;
								next_state = OMC_IDLE;
							end
						end
						else if (state == OMC_WORD_ADDR)
						begin
							next_wordAddr = shiftReg;
							next_state = OMC_ACK_WORD;
						end
						else
						begin
							// Only bit 6 of the control byte is writable.
							if (devSel == OMC_SEL_DIAG &&
								wordAddr == `OMC_CTRL_STATUS_OFS)
							begin
								next_soft = shiftReg[`OMC_BIT_SW_SHUTOFF];
							end
							next_wordAddr = wordAddr + 8'h01;
							next_state = OMC_ACK_WR;
						end
					end
				end
				OMC_ACK_DEV:
				begin
					if (sclFall)
					begin
						next_bitCnt = 4'h0;
						if (isRead)
						begin
							next_shiftReg = loadByte;
							next_pullLow = ~loadByte[7];
							next_state = OMC_RD_DATA;
						end
						else
						begin
							next_pullLow = 1'b0;
							next_state = OMC_WORD_ADDR;
						end
					end
				end
				OMC_ACK_WORD, OMC_ACK_WR:
				begin
					if (sclFall)
					begin
						next_bitCnt = 4'h0;
						next_pullLow = 1'b0;
						next_state = OMC_WR_DATA;
					end
				end
				OMC_RD_DATA:
				begin
					if (sclFall)
					begin
						if (bitCnt == `OMC_LAST_DATA_BIT)
						begin
							// Release for the master's acknowledge.
							next_pullLow = 1'b0;
							next_wordAddr = wordAddr + 8'h01;
							next_state = OMC_RD_ACK;
						end
						else
						begin
							next_shiftReg = {shiftReg[6:0], 1'b0};
							next_pullLow = ~shiftReg[6];
							next_bitCnt = bitCnt + 4'h1;
						end
					end
				end
				OMC_RD_ACK:
				begin
					if (sclRise && sdaIn)
					begin
						// No acknowledge: the master ends the read.
						next_state = OMC_IDLE;
					end
					else if (sclFall)
					begin
						next_bitCnt = 4'h0;
						next_shiftReg = loadByte;
						next_pullLow = ~loadByte[7];
						next_state = OMC_RD_DATA;
					end
				end
				default:
				begin
					next_state = OMC_IDLE;
					next_pullLow = 1'b0;
				end
			endcase
		end
	end

	// Registers of the slave. The pin samples start high, the idle level
	// of the bus, so leaving reset never looks like a stop condition.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state <= OMC_IDLE;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			wordAddr <= 8'h00;
			devSel <= OMC_SEL_ID;
			isRead <= 1'b0;
			pullLow <= 1'b0;
			softShutoff <= `OMC_SW_SHUTOFF_RST;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			state <= next_state;
			bitCnt <= next_bitCnt;
			shiftReg <= next_shiftReg;
			wordAddr <= next_wordAddr;
			devSel <= next_devSel;
			isRead <= next_isRead;
			pullLow <= next_pullLow;
			softShutoff <= next_soft;
			sclPrev <= scl;
			sdaPrev <= sdaIn;
		end
	end

endmodule : omc_ctrl_status

`default_nettype wire

// file: tb/omc_host_model.sv
// Host board model: the pull-ups on the two-wire data line and fault pin.
// Assumes the bench acts as bus master through hostSdaOe.
`timescale 1ns/10ps
`default_nettype none

module omc_host_model
(
	input  wire logic hostSdaOe,
	input  wire logic sdaOe,
	input  wire logic txFaultOe,
	output logic      sdaLine,
	output logic      faultPin
);
	// -----------------------------------------------------------
	// Open-drain lines.
	// -----------------------------------------------------------
	// Any party pulling low wins; otherwise the resistor lifts it.
	assign sdaLine  = !(hostSdaOe || sdaOe);
	// A released fault pin floats high, which means a fault.
	assign faultPin = !txFaultOe;
endmodule : omc_host_model

`default_nettype wire

// file: tb/omc_ctrl_status_monitor.sv
// Assertions on the pins of the optical module control block.
// Assumes all pins are sampled on core_clk.
`timescale 1ns/10ps
`default_nettype none

module omc_ctrl_status_monitor
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic txShutoffLevel,
	input wire logic txShutoffDriven,
	input wire logic catastrophicFault,
	input wire logic unsafeLevel,
	input wire logic signalUnusable,
	input wire logic laserEnable,
	input wire logic txFaultOut,
	input wire logic txFaultOe,
	input wire logic receive_signal_lost,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe
);
	logic hwOff; // Effective shut-off; a floating pin reads as high.

	assign hwOff = txShutoffDriven ? txShutoffLevel : 1'b1;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// -----------------------------------------------------------
	// Laser guard.
	// -----------------------------------------------------------
	shutoff_laser_off_a: assert property (hwOff |=> !laserEnable)
		else $error("laser on while shut off");
	floating_pin_off_a: assert property (!txShutoffDriven |=> !laserEnable)
		else $error("laser on with floating pin");
	fault_trips_laser_a: assert property (catastrophicFault |=> !txFaultOe && !laserEnable)
		else $error("fault did not trip");
	eye_safety_trip_a: assert property (unsafeLevel |=> !txFaultOe && !laserEnable)
		else $error("eye safety did not trip");
	// Only a fresh shut-off assertion may release a latched fault.
	fault_latch_hold_a: assert property (!txFaultOe && !$rose(hwOff) |=> !txFaultOe)
		else $error("fault released early");
	reset_fault_clear_a: assert property ($rose(reset_n) |-> txFaultOe)
		else $error("fault set after reset");
	open_drain_low_a: assert property (!txFaultOut && !sdaOut)
		else $error("open drain drives high");

	// -----------------------------------------------------------
	// Signal lost and bus.
	// -----------------------------------------------------------
	lost_follows_a: assert property (1'b1 |=> receive_signal_lost == $past(signalUnusable))
		else $error("signal lost pin lags");
	// Data may only start being pulled while the bus clock is low.
	sda_changes_low_a: assert property ($rose(sdaOe) |-> !scl)
		else $error("data pulled during clock high");
endmodule : omc_ctrl_status_monitor

bind omc_ctrl_status omc_ctrl_status_monitor u_monitor
(
	.core_clk, .reset_n, .txShutoffLevel, .txShutoffDriven, .catastrophicFault,
	.unsafeLevel, .signalUnusable, .laserEnable, .txFaultOut, .txFaultOe,
	.receive_signal_lost, .scl, .sdaIn, .sdaOut, .sdaOe
);

`default_nettype wire

// file: tb/omc_ctrl_status_test.sv
// Self-checking bench for the optical module control block.
// Assumes the bench is two-wire master and drives every module pin.
`timescale 1ns/10ps
`default_nettype none

module omc_ctrl_status_test;
	localparam logic [7:0] ID_FILL = 8'h5a; // Arbitrary ID byte value.

	logic       core_clk, reset_n, txShutoffLevel, txShutoffDriven;
	logic       catastrophicFault, unsafeLevel, signalUnusable;
	logic       scl, hostSdaOe, sdaIn, sdaOut, sdaOe, faultPin;
	logic       laserEnable, txFaultOut, txFaultOe, receive_signal_lost;
	logic [7:0] rd;          // Last byte read.
	logic       ack, devAck; // Slave answers.
	int         fails, comparisons;

	omc_ctrl_status #(.ID_CONTENTS({256{ID_FILL}})) u_dut
	(
		.core_clk, .reset_n, .txShutoffLevel, .txShutoffDriven,
		.catastrophicFault, .unsafeLevel, .signalUnusable, .laserEnable,
		.txFaultOut, .txFaultOe, .receive_signal_lost, .scl, .sdaIn,
		.sdaOut, .sdaOe
	);

	omc_host_model u_host
	(
		.hostSdaOe, .sdaOe, .txFaultOe, .sdaLine(sdaIn), .faultPin
	);

	// -----------------------------------------------------------
	// Helpers.
	// -----------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One bit; data moves a cycle after the clock falls, for hold time.
	task automatic busBit(input logic pull, output logic seen);
		tick(1);
		hostSdaOe <= pull;
		tick(3);
		scl <= 1'b1;
		tick(2);
		seen = sdaIn;
		tick(2);
		scl <= 1'b0;
	endtask : busBit

	// Start, also usable as a repeated start: SDA falls while SCL is high.
	task automatic busStart();
		tick(1);
		hostSdaOe <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(4);
		hostSdaOe <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask : busStart

	task automatic busStop();
		tick(1);
		hostSdaOe <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(4);
		hostSdaOe <= 1'b0;
		tick(4);
	endtask : busStop

	// Eight bits, most significant first, then the acknowledge slot.
	task automatic busByte(input logic [7:0] d, input logic mAck, output logic [7:0] r);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			busBit(!d[i], b);
			r[i] = b;
		end
		busBit(mAck, b);
		ack = !b;
	endtask : busByte

	task automatic regWrite(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
		logic [7:0] junk;
		busStart();
		busByte({dev, 1'b0}, 1'b0, junk);
		busByte(ptr, 1'b0, junk);
		busByte(d, 1'b0, junk);
		check("wrack", ack, 1'b1);
		busStop();
	endtask : regWrite

	// Random read: pointer write, repeated start, one byte, no ack.
	task automatic regRead(input logic [6:0] dev, input logic [7:0] ptr);
		logic [7:0] junk;
		busStart();
		busByte({dev, 1'b0}, 1'b0, junk);
		devAck = ack;
		busByte(ptr, 1'b0, junk);
		busStart();
		busByte({dev, 1'b1}, 1'b0, junk);
		busByte(8'hff, 1'b0, rd);
		busStop();
	endtask : regRead

	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// -----------------------------------------------------------
	// Clock, watchdog and tests.
	// -----------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// The tests need about 2800 cycles; far beyond that is a hang.
	initial
	begin
		tick(30000);
		fails++;
		print_verdict();
	end

	initial
	begin
		{reset_n, txShutoffLevel, txShutoffDriven, catastrophicFault} = 4'h0;
		{unsafeLevel, signalUnusable, hostSdaOe} = 3'h0;
		scl = 1'b1;
		fails = 0;
		comparisons = 0;
		tick(4);
		reset_n <= 1'b1;
		tick(3);
		check("laser", laserEnable, 1'b0);
		check("fault", faultPin, 1'b0);
		txShutoffDriven <= 1'b1;
		tick(3);
		check("laser", laserEnable, 1'b1);
		regRead(7'h51, 8'h6e);
		check("status", rd, 8'h00);
		check("devack", devAck, 1'b1);
		txShutoffLevel <= 1'b1;
		tick(3);
		check("laser", laserEnable, 1'b0);
		regRead(7'h51, 8'h6e);
		check("status", rd, 8'h80);
		txShutoffLevel <= 1'b0;
		// Every bit written, only the soft shut-off may stick.
		regWrite(7'h51, 8'h6e, 8'hff);
		check("laser", laserEnable, 1'b0);
		regRead(7'h51, 8'h6e);
		check("status", rd, 8'h40);
		regWrite(7'h51, 8'h6e, 8'h00);
		check("laser", laserEnable, 1'b1);
		signalUnusable <= 1'b1;
		tick(3);
		check("lost", receive_signal_lost, 1'b1);
		regRead(7'h51, 8'h6e);
		check("status", rd, 8'h02);
		signalUnusable <= 1'b0;
		catastrophicFault <= 1'b1;
		tick(1);
		catastrophicFault <= 1'b0;
		tick(2);
		check("fault", faultPin, 1'b1);
		check("laser", laserEnable, 1'b0);
		regRead(7'h51, 8'h6e);
		check("status", rd, 8'h04);
		check("fault", faultPin, 1'b1);
		// Spacing between assertions is compressed; the block does not time it.
		txShutoffLevel <= 1'b1;
		tick(2);
		txShutoffLevel <= 1'b0;
		tick(3);
		check("fault", faultPin, 1'b0);
		check("laser", laserEnable, 1'b1);
		unsafeLevel <= 1'b1;
		tick(1);
		unsafeLevel <= 1'b0;
		tick(2);
		check("fault", faultPin, 1'b1);
		txShutoffDriven <= 1'b0;
		tick(2);
		txShutoffDriven <= 1'b1;
		tick(3);
		check("fault", faultPin, 1'b0);
		// A trip in the very cycle of a shut-off assertion must keep the fault.
		txShutoffLevel <= 1'b1;
		unsafeLevel <= 1'b1;
		tick(1);
		unsafeLevel <= 1'b0;
		tick(2);
		check("fault", faultPin, 1'b1);
		txShutoffLevel <= 1'b0;
		tick(3);
		check("laser", laserEnable, 1'b0);
		regRead(7'h50, 8'hff);
		check("idbyte", rd, ID_FILL);
		regRead(7'h52, 8'h6e);
		check("unmapped", devAck, 1'b0);
		print_verdict();
	end
endmodule : omc_ctrl_status_test

`default_nettype wire
